// file: inc/imadr_params.svh
// Offsets, field positions, reset values and sizes of the delay and tx group registers
`ifndef IMADR_PARAMS_SVH
`define IMADR_PARAMS_SVH
`define IMADR_AW          10
`define IMADR_DW          16
`define IMADR_NLINK       16
`define IMADR_NGRP        8
`define IMADR_DLY_W       14
`define IMADR_A_DLYVAL    10'h285
`define IMADR_A_LNKNUM    10'h286
`define IMADR_A_MEMCTL    10'h299
`define IMADR_A_MAXD      10'h29a
`define IMADR_A_DSEL      10'h2aa
`define IMADR_A_RECOMB    10'h2ad
`define IMADR_A_TXG       10'h300
`define IMADR_A_OFFS      10'h310
`define IMADR_MEMCTL_OPT  8
`define IMADR_MEMCTL_RX   7
`define IMADR_MEMCTL_TX   6
`define IMADR_MEMCTL_CNT  5
`define IMADR_DSEL_CLR    6
`define IMADR_DSEL_KLSB   4
`define IMADR_LNK_SRAMT   5
`define IMADR_TXG_MLSB    6
`define IMADR_TXG_ADV     5
`define IMADR_TXG_SCHED   4
`define IMADR_RST_MEMCTL  9'h000
`define IMADR_RST_MAXD    14'h0000
`define IMADR_RST_DSEL    9'h000
`define IMADR_RST_LNKMSC  5'h00
`define IMADR_RST_TXG     9'h0b0
`endif

// file: inc/imadr_pkg.sv
// Types shared by the delay and tx group register bank
`include "imadr_params.svh"
package imadr_pkg;
   // Delay kind, encoded 00 link, 01 group min, 10 group max, 11 max over time
   typedef enum logic [1:0] {DK_LINK, DK_GMIN, DK_GMAX, DK_TMAX} imadr_kind_type;

   // One host register access
   typedef struct packed {
      logic                    wr;
      logic                    rd;
      logic [`IMADR_AW-1:0]    addr;
      logic [`IMADR_DW-1:0]    wdata;
   } imadr_bus_type;

   // Settings of one tx IMA group
   typedef struct packed {
      logic [1:0] m_code;
      logic       adv_ctc;
      logic       sched_ctc;
      logic [3:0] ref_link;
   } imadr_txg_type;
endpackage : imadr_pkg

// file: src/imadr_offset_mask.sv
// Keeps only the control cell offset bits that the frame length uses
`timescale 1ns/1ps
module imadr_offset_mask (
   input  wire logic [1:0] m_code_i,
   input  wire logic [7:0] offset_i,
   output logic      [7:0] offset_o
);
   logic [7:0] mask;

   // 32 cells keep five bits, each doubling one more
   assign mask     = 8'hff >> (2'h3 - m_code_i);
   assign offset_o = offset_i & mask;
endmodule : imadr_offset_mask

// file: src/imadr_delay_latch.sv
// Tracks maximum delay over time and latches the selected delay reading
`timescale 1ns/1ps
module imadr_delay_latch import imadr_pkg::*; #(
   parameter int NLINK = `IMADR_NLINK,
   parameter int NGRP  = `IMADR_NGRP,
   parameter int DW    = `IMADR_DLY_W
) (
   input  wire logic                        clk_i,
   input  wire logic                        arst_n_i,
   input  wire logic                        soft_rst_i,
   input  wire logic                        update_i,
   input  wire logic                        clr_max_i,
   input  wire imadr_kind_type              kind_i,
   input  wire logic [3:0]                  sel_i,
   input  wire logic [NLINK-1:0][DW-1:0]    link_delay_i,
   input  wire logic [NGRP-1:0][DW-1:0]     gmax_i,
   input  wire logic [NGRP-1:0][DW-1:0]     gmin_i,
   input  wire logic [NGRP-1:0][3:0]        gmax_link_i,
   input  wire logic [NGRP-1:0][3:0]        gmin_link_i,
   output logic      [DW-1:0]               value_o,
   output logic      [3:0]                  link_o
);
   logic [NGRP-1:0][DW-1:0] tmax;
   logic [2:0]              grp;
   logic [DW-1:0]           next_value;
   logic [3:0]              next_link;

   assign grp = sel_i[2:0];

   // Running maximum per group, cleared by software command
   for (genvar g = 0; g < NGRP; g++) begin : g_tmax
      always_ff @(posedge clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            tmax[g] <= '0;
         end else if (soft_rst_i || (clr_max_i && grp == 3'(g))) begin
            tmax[g] <= '0;
         end else if (gmax_i[g] > tmax[g]) begin
            tmax[g] <= gmax_i[g];
         end
      end
   end

   // Reading picked by the delay kind
   assign next_value = (kind_i == DK_TMAX) ? tmax[grp] :
                       (kind_i == DK_GMAX) ? gmax_i[grp] :
                       (kind_i == DK_GMIN) ? gmin_i[grp] :
                       link_delay_i[sel_i];
   assign next_link  = (kind_i == DK_GMAX) ? gmax_link_i[grp] :
                       (kind_i == DK_GMIN) ? gmin_link_i[grp] :
                       (kind_i == DK_LINK) ? sel_i : 4'h0;

   // Latch on each update request
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         value_o <= '0;
         link_o  <= 4'h0;
      end else if (soft_rst_i) begin
         value_o <= '0;
         link_o  <= 4'h0;
      end else if (update_i) begin
         value_o <= next_value;
         link_o  <= next_link;
      end
   end
endmodule : imadr_delay_latch

// file: src/imadr_regs.sv
// Delay select, max delay, recombiner status and tx group register bank
//
// Contract
// - Writing ones to memory control bits 7:5 together resets the whole component.
// - Eight 14-bit max operational delay registers, upper two bits read zero.
// - Reset-maximum bit 6 clears the max-over-time value of the chosen group.
// - Kind field 5:4 picks max-over-time, group max, group min or link delay.
// - Link kind uses select bits 3:0, group kinds use bits 2:0.
// - Writing delay select starts an update of the delay readout registers.
// - Recombiner status bit n shows link n recombiner enabled.
// - Group M field 7:6 sets frame length 32, 64, 128 or 256.
// - Bit 5 advertises ITC when zero, CTC when one, in ICP cells.
// - Bit 4 sets scheduler timing ITC or CTC, independent of bit 5.
// - Bits 3:0 name the group's timing reference link.
// - Each offset register holds link N in low byte, N+8 in high.
// - Only offset bits implied by the group's M are used.
// - Unused upper bits of select, max delay and group control read zero.
// - Link number register returns the link of the latched delay reading.
`timescale 1ns/1ps
module imadr_regs import imadr_pkg::*; #(
   parameter int NLINK = `IMADR_NLINK,
   parameter int NGRP  = `IMADR_NGRP,
   parameter int DW    = `IMADR_DLY_W
) (
   input  wire logic                        clk_i,
   input  wire logic                        arst_n_i,
   input  wire imadr_bus_type               bus_i,
   output logic      [`IMADR_DW-1:0]        rdata_o,
   input  wire logic [NLINK-1:0][DW-1:0]    link_delay_i,
   input  wire logic [NGRP-1:0][DW-1:0]     gmax_i,
   input  wire logic [NGRP-1:0][DW-1:0]     gmin_i,
   input  wire logic [NGRP-1:0][3:0]        gmax_link_i,
   input  wire logic [NGRP-1:0][3:0]        gmin_link_i,
   input  wire logic [NLINK-1:0]            recomb_en_i,
   input  wire logic [NLINK-1:0][2:0]       link_group_i,
   output logic                             glob_rst_o,
   output logic      [2:0]                  mem_size_o,
   output logic                             mem_opt_o,
   output logic                             rx_rst_o,
   output logic                             tx_rst_o,
   output logic                             cnt_rst_o,
   output logic                             sram_test_o,
   output logic      [NGRP-1:0][DW-1:0]     max_delay_o,
   output imadr_txg_type [NGRP-1:0]         tx_group_o,
   output logic      [NLINK-1:0][7:0]       offset_o
);
   localparam int NPAIR = NLINK / 2;

   // Stored state
   logic [8:0]                 mem_ctrl;
   logic [8:0]                 dsel;
   logic [4:0]                 lnk_misc;
   logic [NLINK-1:0]           recomb;
   logic [NGRP-1:0][8:0]       txg;
   logic [NPAIR-1:0][15:0]     offs;
   logic                       soft_rst;
   logic                       upd;
   logic [DW-1:0]              dly_value;
   logic [3:0]                 dly_link;

   // Decode wires
   logic [`IMADR_AW-1:0]       maxd_off;
   logic [`IMADR_AW-1:0]       txg_off;
   logic [`IMADR_AW-1:0]       offs_off;
   logic                       hit_memctl;
   logic                       hit_dsel;
   logic                       hit_lnknum;
   logic                       hit_dlyval;
   logic                       hit_recomb;
   logic                       hit_maxd;
   logic                       hit_txg;
   logic                       hit_offs;
   logic [2:0]                 maxd_idx;
   logic [2:0]                 txg_idx;
   logic [2:0]                 offs_idx;
   logic                       next_soft_rst;
   logic [`IMADR_DW-1:0]       next_rdata;
   logic [NLINK-1:0][7:0]      next_offset;

   // Write enables, one per register or register set
   logic                       wr_memctl;
   logic                       wr_dsel;
   logic                       wr_lnknum;
   logic [NGRP-1:0]            wr_maxd;
   logic [NGRP-1:0]            wr_txg;
   logic [NPAIR-1:0]           wr_offs;

   // Delay select fields
   logic                       dsel_clr;
   imadr_kind_type             dsel_kind;
   logic [3:0]                 dsel_sel;
   logic                       clr_req;

   // Read words, unused bits already zero
   logic [`IMADR_DW-1:0]       rd_memctl;
   logic [`IMADR_DW-1:0]       rd_dsel;
   logic [`IMADR_DW-1:0]       rd_lnknum;
   logic [`IMADR_DW-1:0]       rd_dlyval;
   logic [`IMADR_DW-1:0]       rd_recomb;
   logic [`IMADR_DW-1:0]       rd_maxd;
   logic [`IMADR_DW-1:0]       rd_txg;
   logic [`IMADR_DW-1:0]       rd_offs;

   // Per-link view of the group settings
   logic [NLINK-1:0][1:0]      link_m_code;
   logic [NLINK-1:0][7:0]      link_offset;

   // Offsets into the register sets
   assign maxd_off   = bus_i.addr - `IMADR_A_MAXD;
   assign txg_off    = bus_i.addr - `IMADR_A_TXG;
   assign offs_off   = bus_i.addr - `IMADR_A_OFFS;

   // Entry index inside each set
   assign maxd_idx   = maxd_off[2:0];
   assign txg_idx    = txg_off[2:0];
   assign offs_idx   = offs_off[2:0];

   // Single-register hits
   assign hit_memctl = bus_i.addr == `IMADR_A_MEMCTL;
   assign hit_dsel   = bus_i.addr == `IMADR_A_DSEL;
   assign hit_lnknum = bus_i.addr == `IMADR_A_LNKNUM;
   assign hit_dlyval = bus_i.addr == `IMADR_A_DLYVAL;
   assign hit_recomb = bus_i.addr == `IMADR_A_RECOMB;

   // Register set hits, a lower address wraps to a large offset and misses
   assign hit_maxd   = maxd_off < `IMADR_AW'(NGRP);
   assign hit_txg    = txg_off < `IMADR_AW'(NGRP);
   assign hit_offs   = offs_off < `IMADR_AW'(NPAIR);

   // Single-register write enables
   assign wr_memctl = bus_i.wr && hit_memctl;
   assign wr_dsel   = bus_i.wr && hit_dsel;
   assign wr_lnknum = bus_i.wr && hit_lnknum;

   // Delay select fields and the clear request of the max-over-time value
   assign dsel_clr  = dsel[`IMADR_DSEL_CLR];
   assign dsel_kind = imadr_kind_type'(dsel[`IMADR_DSEL_KLSB+1:`IMADR_DSEL_KLSB]);
   assign dsel_sel  = dsel[3:0];
   assign clr_req   = upd && dsel_clr;

   // All three reset bits in one write
   assign next_soft_rst = bus_i.wr && hit_memctl &&
                          (bus_i.wdata[`IMADR_MEMCTL_RX:`IMADR_MEMCTL_CNT] == 3'h7);

   // Global reset pulse, one cycle
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         soft_rst   <= 1'b0;
         glob_rst_o <= 1'b0;
      end else begin
         soft_rst   <= next_soft_rst;
         glob_rst_o <= next_soft_rst;
      end
   end

   // Memory control register
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mem_ctrl <= `IMADR_RST_MEMCTL;
      end else if (soft_rst) begin
         mem_ctrl <= `IMADR_RST_MEMCTL;
      end else if (wr_memctl) begin
         mem_ctrl <= bus_i.wdata[8:0]; // Bit 8 needs bit 0, not enforced
      end
   end

   // Delay select register
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dsel <= `IMADR_RST_DSEL;
      end else if (soft_rst) begin
         dsel <= `IMADR_RST_DSEL;
      end else if (wr_dsel) begin
         dsel <= bus_i.wdata[8:0]; // Bits 8:7 kept as written
      end
   end

   // Update request, one cycle after each select write
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         upd <= 1'b0;
      end else if (soft_rst) begin
         upd <= 1'b0;
      end else begin
         upd <= wr_dsel;
      end
   end

   // Link number register, writable spare bits
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lnk_misc <= `IMADR_RST_LNKMSC;
      end else if (soft_rst) begin
         lnk_misc <= `IMADR_RST_LNKMSC;
      end else if (wr_lnknum) begin
         lnk_misc <= bus_i.wdata[8:4];
      end
   end

   // Recombiner status sampled every cycle; host writes have no effect
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         recomb <= '0;
      end else if (soft_rst) begin
         recomb <= '0;
      end else begin
         recomb <= recomb_en_i;
      end
   end

   // Per-group max delay and tx group control
   for (genvar g = 0; g < NGRP; g++) begin : g_grp
      // Write enables of this group's registers
      assign wr_maxd[g] = bus_i.wr && hit_maxd && maxd_idx == 3'(g);
      assign wr_txg[g]  = bus_i.wr && hit_txg && txg_idx == 3'(g);

      // Maximum operational delay, 14 bits kept
      always_ff @(posedge clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            max_delay_o[g] <= `IMADR_RST_MAXD;
         end else if (soft_rst) begin
            max_delay_o[g] <= `IMADR_RST_MAXD;
         end else if (wr_maxd[g]) begin
            max_delay_o[g] <= bus_i.wdata[DW-1:0];
         end
      end

      // Group control, reserved bit 8 kept as written
      always_ff @(posedge clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            txg[g] <= `IMADR_RST_TXG;
         end else if (soft_rst) begin
            txg[g] <= `IMADR_RST_TXG;
         end else if (wr_txg[g]) begin
            txg[g] <= bus_i.wdata[8:0];
         end
      end

      // Group settings straight from the register
      assign tx_group_o[g].m_code    = txg[g][`IMADR_TXG_MLSB+1:`IMADR_TXG_MLSB];
      assign tx_group_o[g].adv_ctc   = txg[g][`IMADR_TXG_ADV];
      assign tx_group_o[g].sched_ctc = txg[g][`IMADR_TXG_SCHED];
      assign tx_group_o[g].ref_link  = txg[g][3:0];
   end

   // Offset registers, one per link pair, reset to the link numbers
   for (genvar p = 0; p < NPAIR; p++) begin : g_pair
      assign wr_offs[p] = bus_i.wr && hit_offs && offs_idx == 3'(p);

      // Offset pair register
      always_ff @(posedge clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            offs[p] <= {8'(p + NPAIR), 8'(p)};
         end else if (soft_rst) begin
            offs[p] <= {8'(p + NPAIR), 8'(p)};
         end else if (wr_offs[p]) begin
            offs[p] <= bus_i.wdata;
         end
      end
   end

   // Effective offsets masked by each link's group frame length
   for (genvar l = 0; l < NLINK; l++) begin : g_link
      // Low byte serves link N, high byte link N+8
      assign link_offset[l] = l < NPAIR ? offs[l % NPAIR][7:0]
                                        : offs[l % NPAIR][15:8];
      assign link_m_code[l] = tx_group_o[link_group_i[l]].m_code;

      // Keep only the bits that the frame length uses
      imadr_offset_mask u_mask (
         .m_code_i (link_m_code[l]),
         .offset_i (link_offset[l]),
         .offset_o (next_offset[l])
      );

      always_ff @(posedge clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            offset_o[l] <= 8'h00;
         end else begin
            offset_o[l] <= next_offset[l];
         end
      end
   end

   // Delay measurement readout
   imadr_delay_latch #(
      .NLINK (NLINK),
      .NGRP  (NGRP),
      .DW    (DW)
   ) u_latch (
      .clk_i        (clk_i),
      .arst_n_i     (arst_n_i),
      .soft_rst_i   (soft_rst),
      .update_i     (upd),
      .clr_max_i    (clr_req),
      .kind_i       (dsel_kind),
      .sel_i        (dsel_sel),
      .link_delay_i (link_delay_i),
      .gmax_i       (gmax_i),
      .gmin_i       (gmin_i),
      .gmax_link_i  (gmax_link_i),
      .gmin_link_i  (gmin_link_i),
      .value_o      (dly_value),
      .link_o       (dly_link)
   );

   // Memory control fields, and the SRAM test enable from link number bit 5
   assign mem_size_o  = mem_ctrl[2:0];
   assign mem_opt_o   = mem_ctrl[`IMADR_MEMCTL_OPT];
   assign rx_rst_o    = mem_ctrl[`IMADR_MEMCTL_RX];
   assign tx_rst_o    = mem_ctrl[`IMADR_MEMCTL_TX];
   assign cnt_rst_o   = mem_ctrl[`IMADR_MEMCTL_CNT];
   assign sram_test_o = lnk_misc[`IMADR_LNK_SRAMT - 4];

   // Read words, upper bits padded with zero
   assign rd_memctl = {7'h00, mem_ctrl};
   assign rd_dsel   = {7'h00, dsel};
   assign rd_lnknum = {7'h00, lnk_misc, dly_link};
   assign rd_dlyval = {2'h0, dly_value};
   assign rd_recomb = recomb;
   assign rd_maxd   = {2'h0, max_delay_o[maxd_idx]};
   assign rd_txg    = {7'h00, txg[txg_idx]};
   assign rd_offs   = offs[offs_idx];

   // Read selection, unmapped addresses give zero
   assign next_rdata = hit_memctl ? rd_memctl :
                       hit_dsel   ? rd_dsel   :
                       hit_lnknum ? rd_lnknum :
                       hit_dlyval ? rd_dlyval :
                       hit_recomb ? rd_recomb :
                       hit_maxd   ? rd_maxd   :
                       hit_txg    ? rd_txg    :
                       hit_offs   ? rd_offs   :
                       16'h0000;

   // Read data registered, held until the next read
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= 16'h0000;
      end else if (bus_i.rd) begin
         rdata_o <= next_rdata;
      end
   end
endmodule : imadr_regs

// file: testbench/imadr_regs_sva.sv
// Port assertions for the delay and tx group register bank
`timescale 1ns/1ps
`include "imadr_params.svh"
module imadr_regs_sva import imadr_pkg::*; #(
   parameter int NLINK = `IMADR_NLINK,
   parameter int NGRP  = `IMADR_NGRP,
   parameter int DW    = `IMADR_DLY_W
) (
   input  wire logic                     clk_i,
   input  wire logic                     arst_n_i,
   input  wire imadr_bus_type            bus_i,
   input  wire logic [`IMADR_DW-1:0]     rdata_o,
   input  wire logic [NLINK-1:0]         recomb_en_i,
   input  wire logic [NLINK-1:0][2:0]    link_group_i,
   input  wire logic                     glob_rst_o,
   input  wire logic [2:0]               mem_size_o,
   input  wire logic                     mem_opt_o,
   input  wire logic                     rx_rst_o,
   input  wire logic                     tx_rst_o,
   input  wire logic                     cnt_rst_o,
   input  wire logic [NGRP-1:0][DW-1:0]  max_delay_o,
   input  wire imadr_txg_type [NGRP-1:0] tx_group_o,
   input  wire logic [NLINK-1:0][7:0]    offset_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   // Global reset write and its two-cycle aftermath
   sequence s_glob_wr;
      bus_i.wr && bus_i.addr == `IMADR_A_MEMCTL && bus_i.wdata[7:5] == 3'b111;
   endsequence
   sequence s_glob_done;
      glob_rst_o ##1 (!glob_rst_o && tx_group_o[0] == 8'hb0 && max_delay_o[0] == '0);
   endsequence

   a_glob_rst_seq: assert property (s_glob_wr |=> s_glob_done)
      else $error("global reset pulse or register clear wrong");
   a_memctl_store: assert property (
      bus_i.wr && bus_i.addr == `IMADR_A_MEMCTL |=>
      {mem_opt_o, rx_rst_o, tx_rst_o, cnt_rst_o, mem_size_o} ==
      {$past(bus_i.wdata[8:5]), $past(bus_i.wdata[2:0])})
      else $error("memory control fields not stored");
   a_maxd_store: assert property (
      bus_i.wr && bus_i.addr inside {[`IMADR_A_MAXD:`IMADR_A_MAXD + 10'd7]} |=>
      max_delay_o[3'($past(bus_i.addr) - `IMADR_A_MAXD)] == $past(bus_i.wdata[13:0]))
      else $error("max delay not stored");
   a_txg_store: assert property (
      bus_i.wr && bus_i.addr inside {[`IMADR_A_TXG:`IMADR_A_TXG + 10'd7]} |=>
      tx_group_o[$past(bus_i.addr[2:0])] == $past(bus_i.wdata[7:0]))
      else $error("group control not stored");
   a_unmapped_zero: assert property (bus_i.rd && bus_i.addr > 10'h317 |=> rdata_o == '0)
      else $error("unmapped read not zero");
   a_recomb_read: assert property (
      bus_i.rd && bus_i.addr == `IMADR_A_RECOMB && $stable(recomb_en_i) && $past(arst_n_i)
      |=> rdata_o == $past(recomb_en_i))
      else $error("recombiner status read wrong");
   a_upper_zero: assert property (
      bus_i.rd && (bus_i.addr == `IMADR_A_DSEL || bus_i.addr[9:3] == 7'h60)
      |=> rdata_o[15:9] == '0)
      else $error("unused upper bits not zero");
   a_offset_mask: assert property (
      $stable(tx_group_o) && $stable(link_group_i) |->
      8'(offset_o[3] >> (4'd5 + 4'(tx_group_o[link_group_i[3]].m_code))) == 8'h00)
      else $error("offset bits beyond frame length");
endmodule : imadr_regs_sva

bind imadr_regs imadr_regs_sva #(.NLINK(NLINK), .NGRP(NGRP), .DW(DW)) u_sva (
   .clk_i(clk_i), .arst_n_i(arst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
   .recomb_en_i(recomb_en_i), .link_group_i(link_group_i), .glob_rst_o(glob_rst_o),
   .mem_size_o(mem_size_o), .mem_opt_o(mem_opt_o), .rx_rst_o(rx_rst_o),
   .tx_rst_o(tx_rst_o), .cnt_rst_o(cnt_rst_o), .max_delay_o(max_delay_o),
   .tx_group_o(tx_group_o), .offset_o(offset_o));

// file: testbench/imadr_regs_tb.sv
// Self-checking bench for the delay and tx group register bank
`timescale 1ns/1ps
`include "imadr_params.svh"
module imadr_regs_tb import imadr_pkg::*; ;
   logic                clk_i;
   logic                arst_n_i;
   imadr_bus_type       bus_i;
   logic [15:0]         rdata_o;
   logic [15:0][13:0]   link_delay_i;
   logic [7:0][13:0]    gmax_i, gmin_i, max_delay_o;
   logic [7:0][3:0]     gmax_link_i, gmin_link_i;
   logic [15:0]         recomb_en_i;
   logic [15:0][2:0]    link_group_i;
   logic                glob_rst_o, mem_opt_o, rx_rst_o, tx_rst_o, cnt_rst_o, sram_test_o;
   logic [15:0]         txg_val;
   logic [2:0]          mem_size_o;
   imadr_txg_type [7:0] tx_group_o;
   logic [15:0][7:0]    offset_o;
   int                  n_errors = 0;
   int                  checked = 0;

   imadr_regs dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
      .link_delay_i(link_delay_i), .gmax_i(gmax_i), .gmin_i(gmin_i),
      .gmax_link_i(gmax_link_i), .gmin_link_i(gmin_link_i), .recomb_en_i(recomb_en_i),
      .link_group_i(link_group_i), .glob_rst_o(glob_rst_o), .mem_size_o(mem_size_o),
      .mem_opt_o(mem_opt_o), .rx_rst_o(rx_rst_o), .tx_rst_o(tx_rst_o),
      .cnt_rst_o(cnt_rst_o), .sram_test_o(sram_test_o), .max_delay_o(max_delay_o),
      .tx_group_o(tx_group_o), .offset_o(offset_o));

   // Compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // One write strobe, driven at falling edges
   task automatic reg_wr(input logic [9:0] a, input logic [15:0] d);
      @(negedge clk_i);
      bus_i.wr = 1'b1;
      bus_i.addr = a;
      bus_i.wdata = d;
      @(negedge clk_i);
      bus_i.wr = 1'b0;
   endtask : reg_wr

   // One read strobe, data settled by the next falling edge
   task automatic reg_rd(input logic [9:0] a, input logic [15:0] exp);
      @(negedge clk_i);
      bus_i.rd = 1'b1;
      bus_i.addr = a;
      @(negedge clk_i);
      bus_i.rd = 1'b0;
      chk(rdata_o, exp);
   endtask : reg_rd

   // Verdict and end of run
   task automatic close_out();
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out

   // Clock at 125 MHz
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      close_out();
   end

   // Main sequence
   initial begin
      arst_n_i = 1'b0;
      bus_i = '0;
      recomb_en_i = 16'ha5c3;
      link_group_i = '0;
      link_group_i[3] = 3'd1;
      for (int k = 0; k < 16; k++) begin
         link_delay_i[k] = 14'(16'h0100 + k);
      end
      for (int g = 0; g < 8; g++) begin
         gmax_i[g] = 14'(16'h0200 + g);
         gmin_i[g] = 14'(16'h0300 + g);
         gmax_link_i[g] = 4'(g + 8);
         gmin_link_i[g] = 4'(g);
      end
      repeat (2) @(negedge clk_i);
      arst_n_i = 1'b1;
      reg_rd(`IMADR_A_DSEL, 16'h0000);
      reg_rd(`IMADR_A_TXG, 16'h00b0);
      for (int p = 0; p < 8; p++) begin
         reg_rd(10'(`IMADR_A_OFFS + p), 16'((p + 8) * 256 + p));
      end
      for (int g = 0; g < 8; g++) begin
         reg_rd(10'(`IMADR_A_MAXD + g), 16'h0000);
         reg_wr(10'(`IMADR_A_MAXD + g), 16'(16'hfff0 + g));
         reg_rd(10'(`IMADR_A_MAXD + g), 16'(16'h3ff0 + g));
      end
      reg_wr(`IMADR_A_TXG, 16'hfeff);
      reg_rd(`IMADR_A_TXG, 16'h00ff);
      reg_wr(10'(`IMADR_A_OFFS + 3), 16'hffff);
      // Every frame length, timing bits set apart from each other
      for (int m = 0; m < 4; m++) begin
         txg_val = 16'(m * 64 + (m % 2) * 32 + (1 - m % 2) * 16 + m + 4);
         reg_wr(10'(`IMADR_A_TXG + 1), txg_val);
         @(negedge clk_i);
         chk({8'h00, tx_group_o[1]}, txg_val);
         chk({8'h00, offset_o[3]}, 16'(8'hff >> (3 - m)));
         chk({8'h00, offset_o[11]}, 16'h00ff);
      end
      reg_rd(`IMADR_A_RECOMB, 16'ha5c3);
      reg_rd(`IMADR_A_RECOMB, 16'ha5c3);
      reg_wr(10'h3ff, 16'hffff);
      reg_rd(10'h3ff, 16'h0000);
      // Each delay kind, with group select ignoring bit 3
      reg_wr(`IMADR_A_DSEL, 16'h000b);
      reg_rd(`IMADR_A_DLYVAL, 16'h010b);
      reg_rd(`IMADR_A_LNKNUM, 16'h000b);
      reg_wr(`IMADR_A_DSEL, 16'h0015);
      reg_rd(`IMADR_A_DLYVAL, 16'h0305);
      reg_rd(`IMADR_A_LNKNUM, 16'h0005);
      reg_wr(`IMADR_A_DSEL, 16'h002d);
      reg_rd(`IMADR_A_DLYVAL, 16'h0205);
      reg_rd(`IMADR_A_LNKNUM, 16'h000d);
      reg_rd(`IMADR_A_DSEL, 16'h002d);
      gmax_i[5] = 14'h0050;
      reg_wr(`IMADR_A_DSEL, 16'h0035);
      reg_rd(`IMADR_A_DLYVAL, 16'h0205);
      reg_wr(`IMADR_A_DSEL, 16'h0075);
      reg_wr(`IMADR_A_DSEL, 16'h0035);
      reg_rd(`IMADR_A_DLYVAL, 16'h0050);
      // Delay value is read only, spare link number bit 5 drives the test enable
      reg_wr(`IMADR_A_DLYVAL, 16'hffff);
      reg_rd(`IMADR_A_DLYVAL, 16'h0050);
      reg_wr(`IMADR_A_LNKNUM, 16'h0020);
      reg_rd(`IMADR_A_LNKNUM, 16'h0020);
      chk({15'h0000, sram_test_o}, 16'h0001);
      // Memory optimisation with size bit, then global software reset
      reg_wr(`IMADR_A_MEMCTL, 16'h0101);
      reg_rd(`IMADR_A_MEMCTL, 16'h0101);
      chk({15'h0000, mem_opt_o}, 16'h0001);
      reg_wr(`IMADR_A_MEMCTL, 16'h00e0);
      repeat (2) @(negedge clk_i);
      reg_rd(`IMADR_A_MAXD, 16'h0000);
      reg_rd(10'(`IMADR_A_TXG + 1), 16'h00b0);
      reg_rd(`IMADR_A_DSEL, 16'h0000);
      reg_rd(`IMADR_A_MEMCTL, 16'h0000);
      reg_rd(`IMADR_A_LNKNUM, 16'h0000);
      chk({15'h0000, sram_test_o}, 16'h0000);
      close_out();
   end
endmodule : imadr_regs_tb
